// ### rtl/ccu_pkg.sv
package ccu_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned XFER_TIME_MS   = 100;
  localparam int unsigned XFER_CYCLES    = XFER_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned OFF_HOLD_S     = 4;
  localparam int unsigned OFF_HOLD_CYCLES = OFF_HOLD_S * CLK_HZ;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_CYCLES   = BLINK_HALF_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // Status summary byte and enable mask layout
  // ****************************************************************
  localparam int STB_OPR_BIT = 7;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_QST_BIT = 3;
  localparam int STB_ERQ_BIT = 2;
  localparam int STB_RUN_BIT = 0;
  localparam logic [7:0] REQ_USED_MASK = 8'hbc;
  localparam logic [7:0] REQ_MASK_INIT = 8'h00;

  // ****************************************************************
  // Memory cells
  // ****************************************************************
  localparam int unsigned     CELL_COUNT = 4;
  localparam logic [7:0]      CELL_FIRST = 8'h01;
  localparam logic [7:0]      CELL_LAST  = 8'h04;
  localparam logic [1:0]      CELL_DEFAULT_IDX = 2'h0;

  // ****************************************************************
  // Commands and states
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_RECALL     = 4'h0,
    CMD_SAVE       = 4'h1,
    CMD_REQ_MASK   = 4'h2,
    CMD_STB_QUERY  = 4'h3,
    CMD_TRIGGER    = 4'h4,
    CMD_SELF_TEST  = 4'h5,
    CMD_WAIT       = 4'h6,
    CMD_ABORT      = 4'h7,
    CMD_DISP_STATE = 4'h8,
    CMD_DISP_FLASH = 4'h9,
    CMD_DISP_TEST  = 4'ha
  } cmd_code_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_HOLD = 2'b10
  } fsm_type;

endpackage : ccu_pkg

// ### rtl/front_panel_ctrl.sv
`timescale 1ns/10ps
module front_panel_ctrl #(
  parameter int unsigned OFF_HOLD_CYCLES = ccu_pkg::OFF_HOLD_CYCLES,
  parameter int unsigned BLINK_CYCLES    = ccu_pkg::BLINK_CYCLES
) (
  input  wire logic    core_clk,
  input  wire logic    rst,
  panel_link_if.panel  pl
);

  typedef struct packed {
    logic        state_on;
    logic        flash_on;
    logic        test_on;
    logic [31:0] off_count;
    logic [31:0] blink_count;
    logic        blink_phase;
    logic        display_active;
    logic        display_dim;
    logic        display_all_lit;
  } panel_state_type;

  panel_state_type s;
  panel_state_type next_s;

  // ****************************************************************
  // Panel control
  // ****************************************************************
  always_comb begin
    next_s = s;
    if (pl.set_state) begin
      next_s.state_on = pl.set_value;
    end
    if (pl.set_flash) begin
      next_s.flash_on = pl.set_value;
    end
    if (pl.set_test) begin
      next_s.test_on = pl.set_value;
    end
    if (!pl.power_switch_off) begin
      next_s.off_count = 32'h0;
    end else if (s.off_count < OFF_HOLD_CYCLES) begin
      next_s.off_count = s.off_count + 32'h1;
    end else begin
      next_s.state_on = 1'b1;
    end
    if (!s.flash_on) begin
      next_s.blink_count = 32'h0;
      next_s.blink_phase = 1'b0;
    end else if (s.blink_count == BLINK_CYCLES - 1) begin
      next_s.blink_count = 32'h0;
      next_s.blink_phase = ~s.blink_phase;
    end else begin
      next_s.blink_count = s.blink_count + 32'h1;
    end
    next_s.display_active  = next_s.state_on;
    next_s.display_dim     = next_s.blink_phase;
    next_s.display_all_lit = next_s.test_on;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '{state_on: 1'b1, display_active: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign pl.state_on        = s.state_on;
  assign pl.flash_on        = s.flash_on;
  assign pl.test_on         = s.test_on;
  assign pl.display_active  = s.display_active;
  assign pl.display_dim     = s.display_dim;
  assign pl.display_all_lit = s.display_all_lit;

endmodule : front_panel_ctrl

// ### rtl/instrument_common_command_unit.sv
`timescale 1ns/10ps
module instrument_common_command_unit #(
  parameter int          STATE_W         = 32,
  parameter int unsigned XFER_CYCLES     = ccu_pkg::XFER_CYCLES,
  parameter int unsigned OFF_HOLD_CYCLES = ccu_pkg::OFF_HOLD_CYCLES,
  parameter int unsigned BLINK_CYCLES    = ccu_pkg::BLINK_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               cmd_valid,
  input  wire logic [3:0]         cmd_code,
  input  wire logic               cmd_is_query,
  input  wire logic               cmd_has_arg,
  input  wire logic [7:0]         cmd_arg,
  output logic                    cmd_ready,
  output logic                    resp_valid,
  output logic [7:0]              resp_data,
  output logic                    cmd_error,
  input  wire logic [STATE_W-1:0] live_state,
  output logic [STATE_W-1:0]      restore_state,
  output logic                    restore_strobe,
  input  wire logic               operation_summary_in,
  input  wire logic               event_summary_in,
  input  wire logic               message_available_in,
  input  wire logic               questionable_in,
  input  wire logic               error_queue_pending_in,
  input  wire logic               ops_pending,
  input  wire logic               bus_trigger_selected,
  input  wire logic               self_test_fail,
  input  wire logic               wait_trigger_set,
  output logic                    error_log_strobe,
  output logic                    sequencer_trigger,
  output logic                    sequencer_abort,
  output logic                    waiting_for_trigger_bit,
  output logic [7:0]              service_request_enable_mask,
  output logic [7:0]              status_summary_byte,
  output logic                    service_request,
  input  wire logic               power_switch_off,
  output logic                    display_active,
  output logic                    display_dim,
  output logic                    display_all_lit
);

  typedef struct packed {
    ccu_pkg::fsm_type                                fsm;
    logic [31:0]                                     count;
    logic                                            is_recall;
    logic [1:0]                                      cell_idx;
    logic [ccu_pkg::CELL_COUNT-1:0][STATE_W-1:0]     cells;
    logic [7:0]                                      req_mask;
    logic                                            trig_wait;
    logic                                            ready;
    logic                                            resp_valid;
    logic [7:0]                                      resp_data;
    logic                                            cmd_error;
    logic [STATE_W-1:0]                              restore_state;
    logic                                            restore_strobe;
    logic                                            error_log;
    logic                                            seq_trigger;
    logic                                            seq_abort;
    logic [7:0]                                      stb;
    logic                                            rqs;
    logic                                            set_state;
    logic                                            set_flash;
    logic                                            set_test;
    logic                                            set_value;
  } unit_state_type;

  unit_state_type s;
  unit_state_type next_s;
  logic [7:0]     stb_now;
  logic           query_only;
  logic           set_only;

  panel_link_if pl ();

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] summary_byte(input logic [7:0] mask, input logic opr,
                                              input logic esb, input logic mav,
                                              input logic qst, input logic erq,
                                              input logic run);
    logic [7:0] b;
    b = 8'h00;
    b[ccu_pkg::STB_OPR_BIT] = opr;
    b[ccu_pkg::STB_ESB_BIT] = esb;
    b[ccu_pkg::STB_MAV_BIT] = mav;
    b[ccu_pkg::STB_QST_BIT] = qst;
    b[ccu_pkg::STB_ERQ_BIT] = erq;
    b[ccu_pkg::STB_RUN_BIT] = run;
    b[ccu_pkg::STB_RQS_BIT] = |(b & mask & ccu_pkg::REQ_USED_MASK);
    return b;
  endfunction : summary_byte

  function automatic logic bad_cell(input logic has_arg, input logic [7:0] arg);
    return has_arg && ((arg < ccu_pkg::CELL_FIRST) || (arg > ccu_pkg::CELL_LAST));
  endfunction : bad_cell

  // ****************************************************************
  // Command execution
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.resp_valid     = 1'b0;
    next_s.cmd_error      = 1'b0;
    next_s.restore_strobe = 1'b0;
    next_s.error_log      = 1'b0;
    next_s.seq_trigger    = 1'b0;
    next_s.seq_abort      = 1'b0;
    next_s.set_state      = 1'b0;
    next_s.set_flash      = 1'b0;
    next_s.set_test       = 1'b0;
    stb_now = summary_byte(s.req_mask, operation_summary_in, event_summary_in,
                           message_available_in, questionable_in,
                           error_queue_pending_in,
                           (s.fsm != ccu_pkg::ST_IDLE) || ops_pending);
    query_only = (cmd_code == ccu_pkg::CMD_STB_QUERY) || (cmd_code == ccu_pkg::CMD_SELF_TEST);
    set_only   = (cmd_code == ccu_pkg::CMD_RECALL) || (cmd_code == ccu_pkg::CMD_SAVE) ||
                 (cmd_code == ccu_pkg::CMD_TRIGGER) || (cmd_code == ccu_pkg::CMD_WAIT) ||
                 (cmd_code == ccu_pkg::CMD_ABORT);
    case (s.fsm)
      ccu_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          if ((query_only && !cmd_is_query) || (set_only && cmd_is_query)) begin
            next_s.cmd_error = 1'b1;
          end else begin
            case (cmd_code)
              ccu_pkg::CMD_RECALL, ccu_pkg::CMD_SAVE: begin
                if (bad_cell(cmd_has_arg, cmd_arg)) begin
                  next_s.cmd_error = 1'b1;
                end else begin
                  next_s.cell_idx  = cmd_has_arg ? (cmd_arg[1:0] - 2'h1)
                                                 : ccu_pkg::CELL_DEFAULT_IDX;
                  next_s.is_recall = (cmd_code == ccu_pkg::CMD_RECALL);
                  if (cmd_code == ccu_pkg::CMD_SAVE) begin
                    next_s.cells[next_s.cell_idx] = live_state;
                  end
                  next_s.count = 32'h0;
                  next_s.fsm   = ccu_pkg::ST_XFER;
                end
              end
              ccu_pkg::CMD_REQ_MASK: begin
                if (cmd_is_query) begin
                  next_s.resp_valid = 1'b1;
                  next_s.resp_data  = s.req_mask;
                end else begin
                  next_s.req_mask = cmd_arg;
                end
              end
              ccu_pkg::CMD_STB_QUERY: begin
                next_s.resp_valid = 1'b1;
                next_s.resp_data  = stb_now;
              end
              ccu_pkg::CMD_TRIGGER: begin
                next_s.seq_trigger = bus_trigger_selected;
              end
              ccu_pkg::CMD_SELF_TEST: begin
                next_s.resp_valid = 1'b1;
                next_s.resp_data  = {7'h00, self_test_fail};
                next_s.error_log  = self_test_fail;
              end
              ccu_pkg::CMD_WAIT: begin
                next_s.fsm = ccu_pkg::ST_HOLD;
              end
              ccu_pkg::CMD_ABORT: begin
                next_s.seq_abort = 1'b1;
                next_s.trig_wait = 1'b0;
              end
              ccu_pkg::CMD_DISP_STATE, ccu_pkg::CMD_DISP_FLASH,
              ccu_pkg::CMD_DISP_TEST: begin
                if (cmd_is_query) begin
                  next_s.resp_valid = 1'b1;
                  next_s.resp_data  = {7'h00,
                    (cmd_code == ccu_pkg::CMD_DISP_STATE) ? pl.state_on :
                    (cmd_code == ccu_pkg::CMD_DISP_FLASH) ? pl.flash_on : pl.test_on};
                end else begin
                  next_s.set_value = cmd_arg[0];
                  next_s.set_state = (cmd_code == ccu_pkg::CMD_DISP_STATE);
                  next_s.set_flash = (cmd_code == ccu_pkg::CMD_DISP_FLASH);
                  next_s.set_test  = (cmd_code == ccu_pkg::CMD_DISP_TEST);
                end
              end
              default: begin
                next_s.cmd_error = 1'b1;
              end
            endcase
          end
        end
      end
      ccu_pkg::ST_XFER: begin
        if (s.count == XFER_CYCLES - 1) begin
          next_s.fsm = ccu_pkg::ST_IDLE;
          if (s.is_recall) begin
            next_s.restore_state  = s.cells[s.cell_idx];
            next_s.restore_strobe = 1'b1;
          end
        end else begin
          next_s.count = s.count + 32'h1;
        end
      end
      ccu_pkg::ST_HOLD: begin
        if (!ops_pending) begin
          next_s.fsm = ccu_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.fsm = ccu_pkg::ST_IDLE;
      end
    endcase
    if (wait_trigger_set) begin
      next_s.trig_wait = 1'b1;
    end
    next_s.ready = (next_s.fsm == ccu_pkg::ST_IDLE);
    next_s.stb   = summary_byte(next_s.req_mask, operation_summary_in, event_summary_in,
                                message_available_in, questionable_in,
                                error_queue_pending_in,
                                (next_s.fsm != ccu_pkg::ST_IDLE) || ops_pending);
    next_s.rqs   = next_s.stb[ccu_pkg::STB_RQS_BIT];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '{fsm: ccu_pkg::ST_IDLE, req_mask: ccu_pkg::REQ_MASK_INIT, ready: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Front panel
  // ****************************************************************
  assign pl.set_state        = s.set_state;
  assign pl.set_flash        = s.set_flash;
  assign pl.set_test         = s.set_test;
  assign pl.set_value        = s.set_value;
  assign pl.power_switch_off = power_switch_off;

  front_panel_ctrl #(
    .OFF_HOLD_CYCLES (OFF_HOLD_CYCLES),
    .BLINK_CYCLES    (BLINK_CYCLES)
  ) u_panel (
    .core_clk (core_clk),
    .rst      (rst),
    .pl       (pl.panel)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready                   = s.ready;
  assign resp_valid                  = s.resp_valid;
  assign resp_data                   = s.resp_data;
  assign cmd_error                   = s.cmd_error;
  assign restore_state               = s.restore_state;
  assign restore_strobe              = s.restore_strobe;
  assign error_log_strobe            = s.error_log;
  assign sequencer_trigger           = s.seq_trigger;
  assign sequencer_abort             = s.seq_abort;
  assign waiting_for_trigger_bit     = s.trig_wait;
  assign service_request_enable_mask = s.req_mask;
  assign status_summary_byte         = s.stb;
  assign service_request             = s.rqs;
  assign display_active              = pl.display_active;
  assign display_dim                 = pl.display_dim;
  assign display_all_lit             = pl.display_all_lit;

endmodule : instrument_common_command_unit

// ### rtl/panel_link_if.sv
`timescale 1ns/10ps
interface panel_link_if;
  logic set_state;
  logic set_flash;
  logic set_test;
  logic set_value;
  logic power_switch_off;
  logic state_on;
  logic flash_on;
  logic test_on;
  logic display_active;
  logic display_dim;
  logic display_all_lit;

  modport ctrl (
    output set_state, set_flash, set_test, set_value, power_switch_off,
    input  state_on, flash_on, test_on, display_active, display_dim, display_all_lit
  );
  modport panel (
    input  set_state, set_flash, set_test, set_value, power_switch_off,
    output state_on, flash_on, test_on, display_active, display_dim, display_all_lit
  );
endinterface : panel_link_if

// ### tb/ccu_asserts.sv
`timescale 1ns/10ps
module ccu_asserts #(
  parameter int unsigned XFER_CYCLES = 20
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic       cmd_is_query,
  input wire logic       cmd_has_arg,
  input wire logic [7:0] cmd_arg,
  input wire logic       cmd_ready,
  input wire logic       resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic       cmd_error,
  input wire logic       restore_strobe,
  input wire logic       operation_summary_in,
  input wire logic       bus_trigger_selected,
  input wire logic       wait_trigger_set,
  input wire logic       error_log_strobe,
  input wire logic       sequencer_trigger,
  input wire logic       sequencer_abort,
  input wire logic       waiting_for_trigger_bit,
  input wire logic [7:0] service_request_enable_mask,
  input wire logic [7:0] status_summary_byte,
  input wire logic       service_request
);
  logic tk;
  assign tk = cmd_valid && cmd_ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  answer_on_query_a: assert property (resp_valid |-> $past(tk && cmd_is_query))
    else $error("answer without a query");
  rqs_mirror_a: assert property (service_request == status_summary_byte[6] &&
    service_request == |(status_summary_byte & service_request_enable_mask & 8'hbc))
    else $error("service request differs from enabled summary bits");
  opr_follow_a: assert property (!$past(rst) |->
    status_summary_byte[7] == $past(operation_summary_in)) else $error("bit 7 stale");
  xfer_busy_a: assert property (restore_strobe |-> $past(cmd_ready, XFER_CYCLES) == 1'b0)
    else $error("recall finished early");
  recall_busy_a: assert property (tk && cmd_code == ccu_pkg::CMD_RECALL && !cmd_is_query &&
    (!cmd_has_arg || cmd_arg inside {[8'h01:8'h04]}) |=> !cmd_ready [*8])
    else $error("recall not busy");
  trig_gate_a: assert property (sequencer_trigger |->
    $past(tk && bus_trigger_selected && cmd_code == ccu_pkg::CMD_TRIGGER))
    else $error("trigger without cause");
  selftest_log_a: assert property (error_log_strobe |-> resp_valid && resp_data == 8'h01)
    else $error("error logged without fail answer");
  abort_clear_a: assert property (tk && cmd_code == ccu_pkg::CMD_ABORT && !cmd_is_query &&
    !wait_trigger_set |=> sequencer_abort && !waiting_for_trigger_bit) else $error("abort");
  form_refuse_a: assert property (tk && cmd_code == ccu_pkg::CMD_STB_QUERY && !cmd_is_query
    |=> cmd_error && !resp_valid) else $error("query-only form accepted");
  wait_hold_a: assert property (tk && cmd_code == ccu_pkg::CMD_WAIT && !cmd_is_query
    |=> !cmd_ready) else $error("wait did not hold");
  cover property (restore_strobe);
  cover property (sequencer_trigger);
  cover property (error_log_strobe);
endmodule : ccu_asserts
bind instrument_common_command_unit ccu_asserts #(.XFER_CYCLES(XFER_CYCLES)) chk (
  .core_clk, .rst, .cmd_valid, .cmd_code, .cmd_is_query, .cmd_has_arg, .cmd_arg, .cmd_ready,
  .resp_valid, .resp_data, .cmd_error, .restore_strobe, .operation_summary_in,
  .bus_trigger_selected, .wait_trigger_set, .error_log_strobe, .sequencer_trigger,
  .sequencer_abort, .waiting_for_trigger_bit, .service_request_enable_mask,
  .status_summary_byte, .service_request);

// ### tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic       core_clk,
  input wire logic       cmd_ready,
  input wire logic       resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic       cmd_error,
  output logic           cmd_valid,
  output logic [3:0]     cmd_code,
  output logic           cmd_is_query,
  output logic           cmd_has_arg,
  output logic [7:0]     cmd_arg
);
  logic       rv;
  logic [7:0] rd;
  logic       er;
  initial begin
    cmd_valid = 0;
    cmd_code = 4'hf;
    cmd_is_query = 0;
    cmd_has_arg = 0;
    cmd_arg = 8'h00;
  end
  // Hold request until taken
  task automatic send(input logic [3:0] c, input logic q, input logic h, input logic [7:0] a);
    @(negedge core_clk);
    cmd_valid = 1;
    cmd_code = c;
    cmd_is_query = q;
    cmd_has_arg = h;
    cmd_arg = a;
    while (cmd_ready !== 1'b1) begin
      @(negedge core_clk);
    end
    @(posedge core_clk);
    @(negedge core_clk);
    cmd_valid = 0;
    cmd_arg = ~a;
    cmd_code = ~c;
    rv = resp_valid;
    rd = resp_data;
    er = cmd_error;
  endtask : send
endmodule : host_model

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  localparam int XC = 20;
  logic core_clk = 0, rst = 1, ops_pending = 0, bus_trigger_selected = 0, self_test_fail = 0;
  logic wait_trigger_set = 0, power_switch_off = 0;
  logic [4:0] sum_in = 0;
  logic [31:0] live_state = 0;
  wire cmd_valid, cmd_is_query, cmd_has_arg, cmd_ready, resp_valid, cmd_error, restore_strobe;
  wire error_log_strobe, sequencer_trigger, sequencer_abort, waiting_for_trigger_bit;
  wire service_request, display_active, display_dim, display_all_lit;
  wire [3:0] cmd_code;
  wire [7:0] cmd_arg, resp_data, service_request_enable_mask, status_summary_byte;
  wire [31:0] restore_state;
  int fail_count = 0, n_compared = 0;
  int pos[5] = '{7, 5, 4, 3, 2};
  always #5 core_clk = ~core_clk;
  host_model host (.core_clk, .cmd_ready, .resp_valid, .resp_data, .cmd_error, .cmd_valid,
    .cmd_code, .cmd_is_query, .cmd_has_arg, .cmd_arg);
  instrument_common_command_unit #(.STATE_W(32), .XFER_CYCLES(XC), .OFF_HOLD_CYCLES(30),
    .BLINK_CYCLES(4)) uut (.core_clk, .rst, .cmd_valid, .cmd_code, .cmd_is_query, .cmd_has_arg,
    .cmd_arg, .cmd_ready, .resp_valid, .resp_data, .cmd_error, .live_state, .restore_state,
    .restore_strobe, .operation_summary_in(sum_in[4]), .event_summary_in(sum_in[3]),
    .message_available_in(sum_in[2]), .questionable_in(sum_in[1]),
    .error_queue_pending_in(sum_in[0]), .ops_pending, .bus_trigger_selected, .self_test_fail,
    .wait_trigger_set, .error_log_strobe, .sequencer_trigger, .sequencer_abort,
    .waiting_for_trigger_bit, .service_request_enable_mask, .status_summary_byte,
    .service_request, .power_switch_off, .display_active, .display_dim, .display_all_lit);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic recall(input logic h, input logic [7:0] a, input logic [31:0] exp);
    int n;
    host.send(ccu_pkg::CMD_RECALL, 0, h, a);
    n = 0;
    while (restore_strobe !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(restore_state, exp);
    chk(n >= XC && n <= XC + 2, 1);
  endtask : recall
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    int t;
    logic [7:0] e;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) rst = 0;
    chk(service_request_enable_mask, 0);
    chk(display_active, 1);
    host.send(ccu_pkg::CMD_REQ_MASK, 0, 1, 8'hff);
    host.send(ccu_pkg::CMD_REQ_MASK, 1, 0, 0);
    chk(host.rd, 8'hff);
    for (int i = 0; i < 5; i++) begin
      e = 8'h01 << pos[i];
      host.send(ccu_pkg::CMD_REQ_MASK, 0, 1, e | 8'h43);
      sum_in = 5'h1f ^ (5'h10 >> i);
      cyc(3);
      chk(service_request, 0);
      sum_in = 5'h10 >> i;
      cyc(3);
      chk(status_summary_byte, e | 8'h40);
      host.send(ccu_pkg::CMD_STB_QUERY, 1, 0, 0);
      chk(host.rd, e | 8'h40);
    end
    sum_in = 0;
    host.send(ccu_pkg::CMD_STB_QUERY, 0, 0, 0);
    chk({host.er, host.rv}, 2'b10);
    bus_trigger_selected = 1;
    host.send(ccu_pkg::CMD_TRIGGER, 1, 0, 0);
    chk({host.er, sequencer_trigger}, 2'b10);
    host.send(4'hb, 0, 0, 0);
    chk({host.er, host.rv}, 2'b10);
    for (int c = 1; c <= 4; c++) begin
      live_state = 32'h11111111 * c;
      host.send(ccu_pkg::CMD_SAVE, 0, 1, c[7:0]);
    end
    live_state = 32'hcafe0000;
    host.send(ccu_pkg::CMD_SAVE, 0, 0, 0);
    chk({cmd_ready, status_summary_byte[0]}, 2'b01);
    for (int c = 2; c <= 4; c++) recall(1, c[7:0], 32'h11111111 * c);
    recall(0, 0, 32'hcafe0000);
    host.send(ccu_pkg::CMD_SAVE, 0, 1, 8'h05);
    chk(host.er, 1);
    host.send(ccu_pkg::CMD_RECALL, 0, 1, 8'h00);
    chk(host.er, 1);
    for (int s = 0; s < 2; s++) begin
      bus_trigger_selected = s[0];
      host.send(ccu_pkg::CMD_TRIGGER, 0, 0, 0);
      chk(sequencer_trigger, s);
      self_test_fail = s[0];
      host.send(ccu_pkg::CMD_SELF_TEST, 1, 0, 0);
      chk({error_log_strobe, host.rd}, {s[0], 8'h00 | s[7:0]});
    end
    ops_pending = 1;
    host.send(ccu_pkg::CMD_WAIT, 0, 0, 0);
    cyc(5);
    chk({cmd_ready, status_summary_byte[0]}, 2'b01);
    ops_pending = 0;
    cyc(3);
    chk(cmd_ready, 1);
    wait_trigger_set = 1;
    cyc(1);
    wait_trigger_set = 0;
    cyc(1);
    chk(waiting_for_trigger_bit, 1);
    host.send(ccu_pkg::CMD_ABORT, 0, 0, 0);
    chk(sequencer_abort, 1);
    cyc(1);
    chk({sequencer_abort, waiting_for_trigger_bit}, 2'b00);
    host.send(ccu_pkg::CMD_DISP_STATE, 0, 1, 0);
    cyc(3);
    chk(display_active, 0);
    host.send(ccu_pkg::CMD_DISP_STATE, 1, 0, 0);
    chk(host.rd[0], 0);
    power_switch_off = 1;
    cyc(10);
    power_switch_off = 0;
    cyc(3);
    chk(display_active, 0);
    power_switch_off = 1;
    cyc(40);
    power_switch_off = 0;
    cyc(3);
    chk(display_active, 1);
    host.send(ccu_pkg::CMD_DISP_TEST, 0, 1, 1);
    cyc(3);
    chk(display_all_lit, 1);
    host.send(ccu_pkg::CMD_DISP_TEST, 0, 1, 0);
    cyc(3);
    chk(display_all_lit, 0);
    host.send(ccu_pkg::CMD_DISP_FLASH, 0, 1, 1);
    t = 0;
    repeat (16) begin
      e[0] = display_dim;
      cyc(1);
      if (display_dim !== e[0]) t++;
    end
    chk(t >= 3 && t <= 4, 1);
    host.send(ccu_pkg::CMD_DISP_FLASH, 1, 0, 0);
    chk(host.rd[0], 1);
    host.send(ccu_pkg::CMD_DISP_FLASH, 0, 1, 0);
    cyc(3);
    chk(display_dim, 0);
    give_verdict();
  end
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
endmodule : tb
